// file: hw/pmt8_pkg.sv
// constants, register map and bus carrier types of the period match timer
package pmt8_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_COUNT = 3'h1;
  localparam logic [2:0] OFS_PERIOD = 3'h2;
  localparam logic [2:0] OFS_IRQ_FLAGS = 3'h3;
  localparam logic [2:0] OFS_IRQ_ENABLES = 3'h4;
  // control field positions
  localparam int CTL_PRESCALE_LSB = 0;
  localparam int CTL_ON_BIT = 2;
  localparam int CTL_POSTSCALE_LSB = 3;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h7f;
  // interrupt bit position in flag and enable registers
  localparam int IRQ_MATCH_BIT = 1;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  // instruction clock is the oscillator divided by four
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
  // prescaler terminal counts
  localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
  localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16 = 4'hf;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pmt8_bus_req_t;

  typedef struct packed {
    logic [3:0] postscale;
    logic on;
    logic [1:0] prescale;
  } pmt8_ctl_t;
endpackage : pmt8_pkg

// file: hw/pmt8_timer.sv
// 8-bit period match timer with prescaler, postscaler and interrupt
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module pmt8_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire pmt8_pkg::pmt8_bus_req_t bus_req,
  output logic [7:0] rdata_q,
  // interrupt
  output logic irq_q,
  // match outputs
  output logic ssp_shift_clk_q,
  output logic timebase_q
);
  logic [7:0] count_q, count_d;
  logic [7:0] period_q;
  logic [6:0] ctl_q;
  logic [1:0] div_q;
  logic [3:0] pre_q, pre_d;
  logic [3:0] post_q, post_d;
  logic flag_q, flag_d;
  logic en_q;
  pmt8_pkg::pmt8_ctl_t ctl;

  // decode
  wire wr_ctl = bus_req.wr && bus_req.addr == pmt8_pkg::OFS_CONTROL;
  wire wr_cnt = bus_req.wr && bus_req.addr == pmt8_pkg::OFS_COUNT;
  wire wr_per = bus_req.wr && bus_req.addr == pmt8_pkg::OFS_PERIOD;
  wire wr_flg = bus_req.wr && bus_req.addr == pmt8_pkg::OFS_IRQ_FLAGS;
  wire wr_ena = bus_req.wr && bus_req.addr == pmt8_pkg::OFS_IRQ_ENABLES;
  assign ctl = pmt8_pkg::pmt8_ctl_t'(ctl_q);

  // instruction tick, prescale limit, count tick
  wire instr_tick = div_q == pmt8_pkg::INSTR_LAST;
  wire [3:0] pre_last = ctl.prescale[1] ? pmt8_pkg::PRE_LAST_DIV16 :
                        ctl.prescale[0] ? pmt8_pkg::PRE_LAST_DIV4 : pmt8_pkg::PRE_LAST_DIV1;
  wire clr_scalers = wr_ctl || wr_cnt;
  wire run = ctl.on && !clr_scalers;
  wire count_tick = run && instr_tick && pre_q == pre_last;
  wire equal = count_q == period_q;
  wire match = count_tick && equal;
  wire post_done = match && post_q == ctl.postscale;

  always_comb begin
    pre_d = pre_q;
    if (clr_scalers) begin
      pre_d = 4'h0;
    end else if (run && instr_tick) begin
      pre_d = (pre_q == pre_last) ? 4'h0 : 4'(pre_q + 4'h1);
    end
  end

  always_comb begin
    post_d = post_q;
    if (clr_scalers) begin
      post_d = 4'h0;
    end else if (match) begin
      post_d = post_done ? 4'h0 : 4'(post_q + 4'h1);
    end
  end

  always_comb begin
    count_d = count_q;
    if (wr_cnt) begin
      count_d = bus_req.wdata;
    end else if (count_tick) begin
      count_d = equal ? 8'h00 : 8'(count_q + 8'h01);
    end
  end

  // sticky flag, set wins over a write-one clear
  always_comb begin
    flag_d = flag_q;
    if (wr_flg && bus_req.wdata[pmt8_pkg::IRQ_MATCH_BIT]) begin
      flag_d = 1'b0;
    end
    if (post_done) begin
      flag_d = 1'b1;
    end
  end

  // read mux
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (bus_req.addr)
      pmt8_pkg::OFS_CONTROL: rd_mux = {1'b0, ctl_q};
      pmt8_pkg::OFS_COUNT: rd_mux = count_q;
      pmt8_pkg::OFS_PERIOD: rd_mux = period_q;
      pmt8_pkg::OFS_IRQ_FLAGS: rd_mux = 8'(flag_q) << pmt8_pkg::IRQ_MATCH_BIT;
      pmt8_pkg::OFS_IRQ_ENABLES: rd_mux = 8'(en_q) << pmt8_pkg::IRQ_MATCH_BIT;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count_q <= pmt8_pkg::RST_COUNT;
      period_q <= pmt8_pkg::RST_PERIOD;
      ctl_q <= pmt8_pkg::RST_CONTROL[6:0];
      pre_q <= 4'h0;
      post_q <= 4'h0;
      div_q <= 2'h0;
      flag_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      count_q <= count_d;
      pre_q <= pre_d;
      post_q <= post_d;
      flag_q <= flag_d;
      div_q <= 2'(div_q + 2'h1);
      if (wr_per) begin
        period_q <= bus_req.wdata;
      end
      if (wr_ctl) begin
        ctl_q <= bus_req.wdata[6:0];
      end
      if (wr_ena) begin
        en_q <= bus_req.wdata[pmt8_pkg::IRQ_MATCH_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      ssp_shift_clk_q <= 1'b0;
      timebase_q <= 1'b0;
    end else begin
      rdata_q <= bus_req.rd ? rd_mux : 8'h00;
      irq_q <= flag_d && (wr_ena ? bus_req.wdata[pmt8_pkg::IRQ_MATCH_BIT] : en_q);
      ssp_shift_clk_q <= match;
      timebase_q <= match;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_count_wraps: assert property (count_tick && equal && !wr_cnt |=> count_q == 8'h00)
    else $error("count did not return to zero after match");
  a_count_steps: assert property (count_tick && !equal && !wr_cnt |=> count_q == 8'($past(count_q) + 8'h01))
    else $error("count did not step by one");
  a_off_holds: assert property (!ctl.on && !wr_cnt ##1 !ctl.on |-> $stable(count_q) && !timebase_q)
    else $error("count moved while timer off");
  a_ctl_keeps_count: assert property (wr_ctl |=> count_q == $past(count_q))
    else $error("control write changed count");
  a_scalers_clear: assert property (wr_ctl || wr_cnt |=> pre_q == 4'h0 && post_q == 4'h0)
    else $error("prescaler or postscaler not cleared");
  a_flag_sets: assert property (post_done |=> flag_q ##0 irq_q == en_q)
    else $error("flag not set at postscale end");
  a_irq_gated: assert property (irq_q |-> en_q && flag_q)
    else $error("interrupt without enable and flag");
  a_match_out: assert property (count_tick && equal |=> ssp_shift_clk_q && timebase_q)
    else $error("match output missing");
  a_div4_gap: assert property (ctl.prescale == 2'b01 && count_tick
    |=> (!count_tick || ctl.prescale != 2'b01) [*8])
    else $error("divide by four ticks too close");
  a_ctl_bit7: assert property (bus_req.rd && bus_req.addr == pmt8_pkg::OFS_CONTROL |=> rdata_q[7] == 1'b0)
    else $error("control bit 7 read nonzero");
  a_reset_vals: assert property (disable iff (1'b0) !resetn |=> count_q == 8'h00 && period_q == 8'hff)
    else $error("reset values wrong");

  c_match: cover property (match);
  c_flag_set: cover property (post_done && ctl.postscale == 4'hf);
  c_set_vs_clear: cover property (post_done && wr_flg);
endmodule : pmt8_timer

// file: tb/pmt8_far_model.sv
// far side: serial port shift clock receiver and capture/compare time base
`timescale 1ns/1ns
module pmt8_far_model (
  // clock
  input wire logic mclk,
  // match inputs
  input wire logic shift_clk,
  input wire logic timebase,
  // observations
  output int shifts,
  output int skew
);
  initial begin
    shifts = 0;
    skew = 0;
  end
  always @(posedge mclk) begin
    if (shift_clk === 1'b1) shifts <= shifts + 1;
    if (shift_clk !== timebase) skew <= skew + 1;
  end
endmodule : pmt8_far_model

// file: tb/test_period_match_timer8.sv
// self-checking bench of the period match timer
`timescale 1ns/1ns
module test_period_match_timer8;
  localparam logic [2:0] CTL = pmt8_pkg::OFS_CONTROL;
  localparam logic [2:0] CNT = pmt8_pkg::OFS_COUNT;
  localparam logic [2:0] PER = pmt8_pkg::OFS_PERIOD;
  localparam logic [2:0] FLG = pmt8_pkg::OFS_IRQ_FLAGS;
  localparam logic [2:0] ENA = pmt8_pkg::OFS_IRQ_ENABLES;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  pmt8_pkg::pmt8_bus_req_t bus_req = '0;
  logic [7:0] rdata_q;
  logic irq_q, ssp_q, tbase_q;
  int shifts, skew, n, t;
  int num_errors = 0;
  int checked = 0;
  always #5 mclk = ~mclk;
  pmt8_timer i_dut (.mclk(mclk), .resetn(resetn), .bus_req(bus_req), .rdata_q(rdata_q), .irq_q(irq_q),
    .ssp_shift_clk_q(ssp_q), .timebase_q(tbase_q));
  pmt8_far_model i_far (.mclk(mclk), .shift_clk(ssp_q), .timebase(tbase_q), .shifts(shifts), .skew(skew));
  task automatic results;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    chk(name, {8'h00, exp}, {8'h00, rdata_q});
  endtask : rd
  // cycles until the next match pulse, or the interrupt when use_irq is set, bounded at 2000
  task automatic wait_for(input bit use_irq);
    t = 0;
    do begin
      @(posedge mclk);
      #1;
      t++;
      if (t > 2000) begin
        num_errors++;
        results();
      end
    end while ((use_irq ? irq_q : ssp_q) !== 1'b1);
  endtask : wait_for
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd("control", CTL, 8'h00);
    rd("count", CNT, 8'h00);
    rd("period", PER, 8'hff);
    rd("flags", FLG, 8'h00);
    rd("unmapped", 3'h5, 8'h00);
    wr(CTL, 8'hff);
    rd("control bit 7", CTL, 8'h7f);
    $display("reset and map test done");
    wr(CTL, 8'h00);
    wr(PER, 8'h03);
    wr(CNT, 8'h00);
    rd("count write", CNT, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(CTL, 8'(4 + p));
      wait_for(1'b0);
      wait_for(1'b0);
      chk("interval", 16'(16 * (p == 0 ? 1 : (p == 1 ? 4 : 16))), 16'(t));
    end
    $display("prescale test done");
    wr(CTL, 8'h10);
    wr(ENA, 8'h02);
    wr(FLG, 8'h02);
    n = shifts;
    wr(CTL, 8'h14);
    wait_for(1'b1);
    @(posedge mclk);
    #1;
    chk("postscale", 16'd3, 16'(shifts - n));
    rd("flag set", FLG, 8'h02);
    wr(ENA, 8'h00);
    @(posedge mclk);
    #1;
    chk("irq masked", 16'h0000, {15'h0000, irq_q});
    $display("interrupt test done");
    wr(CTL, 8'h10);
    wr(FLG, 8'h02);
    rd("flag clear", FLG, 8'h00);
    wr(CNT, 8'h02);
    repeat (40) @(posedge mclk);
    rd("count held", CNT, 8'h02);
    wr(CTL, 8'h13);
    rd("count kept", CNT, 8'h02);
    chk("skew", 16'h0000, 16'(skew));
    $display("hold test done");
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd("count after reset", CNT, 8'h00);
    rd("period after reset", PER, 8'hff);
    rd("control after reset", CTL, 8'h00);
    $display("reset test done");
    results();
  end
endmodule : test_period_match_timer8
